// ==== logic/i2c_baud_gen.v ====
// Reloading phase tick generator for the two-wire master
`timescale 1ns/1ps
`include "i2c_master_defs.vh"

module i2c_baud_gen (
  input  wire       clock,   // System clock
  input  wire       rst_n,   // Synchronous reset, active low
  input  wire       run,     // Count while high, cleared while low
  input  wire [6:0] reload,  // Reload value, seven bits
  output wire       tick     // One-cycle pulse per phase
);

  // ==========================================
  // Counter
  wire [8:0] limit;          // Terminal count of one phase
  reg  [8:0] cnt_r;          // Running count
  reg  [8:0] cnt_nxt;        // Next count

  // Phase = (reload+1) * 4 clocks: the prescale lets seven
  // bits reach 100 kHz at a 200 MHz system clock
  assign limit = {reload, `PRE_FILL};  // RULE8
  assign tick  = run & (cnt_r == limit);

  // Next count; idle clears so every start is a full phase
  always @* begin
    if (!run) begin
      cnt_nxt = 9'h000;
    end else if (tick) begin
      cnt_nxt = 9'h000;
    end else begin
      cnt_nxt = cnt_r + 9'h001;
    end
  end

  // Count register
  always @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= 9'h000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule // i2c_baud_gen

// ==== logic/i2c_master_defs.vh ====
// Constants for the two-wire master sequencer
`ifndef I2C_MASTER_DEFS_VH
`define I2C_MASTER_DEFS_VH

// ==========================================
// Register byte addresses
`define ADR_CON2        4'h0
`define ADR_BUF         4'h4
`define ADR_BAUD        4'h8
`define ADR_STAT        4'hC

// ==========================================
// Second control register fields
`define CON2_START      0
`define CON2_RSTART     1
`define CON2_STOP       2
`define CON2_ACKDT      5
`define CON2_ACKST      6

// ==========================================
// Status register fields
`define STAT_FLAG       0
`define STAT_OWNED      1
`define STAT_BUSY       2
`define STAT_RDMODE     3

// ==========================================
// Reset values
`define BAUD_RST        7'h7F
`define ACKDT_RST       1'b0

// ==========================================
// Baud timing: one phase lasts (reload+1)*4 clocks,
// one SCL period four phases
`define PRE_BITS        2
`define PRE_FILL        2'h3

// ==========================================
// Sequencer states
`define ST_IDLE         3'h0
`define ST_START        3'h1
`define ST_RSTART       3'h2
`define ST_STOP         3'h3
`define ST_BYTE         3'h4

// Bit index of the acknowledge slot
`define ACK_SLOT        4'h8

`endif

// ==== logic/i2c_master_sequencer.v ====
// Two-wire bus master sequencer with a Wishbone register port
// How it works
// RULE1 - Block makes all SCL pulses, START, STOP
// RULE2 - Transfer ends by STOP or Repeated START
// RULE3 - Write address byte ends in zero bit
// RULE4 - Transmit eight bits, then sample acknowledge
// RULE5 - Read address byte ends in one bit
// RULE6 - Receive eight bits, then send acknowledge
// RULE7 - Baud generator sets 100k, 400k, 1M
// RULE8 - Reload uses low seven bits only
// RULE9 - Buffer write starts the baud generator
// RULE10 - After completion baud stops, SCL holds
// RULE11 - Software sets start request bit zero
// RULE12 - START sets flag, blocks until done
// RULE13 - Address byte loaded, all eight bits sent
// RULE14 - Acknowledge stored at control bit six
// RULE15 - Flag rises after ninth SCL clock
// RULE16 - Software loads each data byte
// RULE17 - Software sets stop request bit two
// RULE18 - Flag rises when STOP is complete
// RULE19 - Lines only pulled low or released
// RULE20 - Software clears flag before next step
`timescale 1ns/1ps
`include "i2c_master_defs.vh"

module i2c_master_sequencer (
  input  wire        clock,     // System clock, 200 MHz
  input  wire        rst_n,     // Synchronous reset, active low
  input  wire        wb_cyc_i,  // Wishbone cycle
  input  wire        wb_stb_i,  // Wishbone strobe
  input  wire        wb_we_i,   // Wishbone write enable
  input  wire [3:0]  wb_adr_i,  // Wishbone byte address
  input  wire [31:0] wb_dat_i,  // Wishbone write data
  input  wire [3:0]  wb_sel_i,  // Wishbone byte selects
  output wire [31:0] wb_dat_o,  // Wishbone read data
  output wire        wb_ack_o,  // Wishbone acknowledge
  input  wire        scl_in,    // SCL pin level
  output wire        scl_out,   // SCL pin output value
  output wire        scl_oe_n,  // SCL pull-down, active low
  input  wire        sda_in,    // SDA pin level
  output wire        sda_out,   // SDA pin output value
  output wire        sda_oe_n   // SDA pull-down, active low
);

  // ==========================================
  // Declarations
  reg        scl_meta_r;   // SCL synchroniser, first stage
  reg        scl_sync_r;   // SCL synchroniser, second stage
  reg        sda_meta_r;   // SDA synchroniser, first stage
  reg        sda_sync_r;   // SDA synchroniser, second stage
  reg  [2:0] state_r;      // Sequencer state
  reg  [1:0] phase_r;      // Quarter of the SCL period
  reg  [3:0] bit_r;        // Bit slot within a byte, 8 = ack
  reg  [7:0] shift_r;      // Shift buffer
  reg        scl_low_r;    // Pull SCL low
  reg        sda_low_r;    // Pull SDA low
  reg        flag_r;       // Completion flag
  reg        ack_stat_r;   // Acknowledge seen from slave
  reg        ack_dt_r;     // Acknowledge value to send
  reg        owned_r;      // Bus held by this master
  reg        addr_next_r;  // Next byte is an address byte
  reg        rd_mode_r;    // Address asked for a read
  reg        byte_rx_r;    // Current byte is received
  reg  [6:0] reload_r;     // Baud reload register
  reg        ack_r;        // Wishbone acknowledge
  reg [31:0] dat_r;        // Wishbone read data
  reg [31:0] rd_nxt;       // Read mux result

  wire       req;          // Valid bus request this cycle
  wire       wr;           // Write of the low byte
  wire       wr_con2;      // Write to control register
  wire       wr_buf;       // Write to shift buffer
  wire       wr_baud;      // Write to baud reload
  wire       wr_stat;      // Write to status register
  wire       idle;         // Sequencer free
  wire       go_start;     // Accepted START request
  wire       go_rstart;    // Accepted Repeated START
  wire       go_stop;      // Accepted STOP request
  wire       go_byte;      // Accepted buffer write
  wire       tick;         // One baud phase has passed
  wire       advance;      // Phase may move on
  wire       done;         // Operation finishes now
  wire       drive_bit;    // Level of SDA in next slot

  // ==========================================
  // Pin synchronisers
  // Both lines come from outside; two stages before use
  always @(posedge clock) begin
    if (!rst_n) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_in;
      scl_sync_r <= scl_meta_r;
      sda_meta_r <= sda_in;
      sda_sync_r <= sda_meta_r;
    end
  end

  // ==========================================
  // Open-drain pins
  // Output value is always low; only the enable moves,
  // so a line is never driven high
  assign scl_out  = 1'b0;        // RULE19
  assign sda_out  = 1'b0;        // RULE19
  assign scl_oe_n = ~scl_low_r;  // RULE19
  assign sda_oe_n = ~sda_low_r;  // RULE19

  // ==========================================
  // Bus decode
  // Only the low byte lane holds register bits
  assign req     = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr      = req & wb_we_i & wb_sel_i[0];
  assign wr_con2 = wr & (wb_adr_i == `ADR_CON2);
  assign wr_buf  = wr & (wb_adr_i == `ADR_BUF);
  assign wr_baud = wr & (wb_adr_i == `ADR_BAUD);
  assign wr_stat = wr & (wb_adr_i == `ADR_STAT);

  // ==========================================
  // Request acceptance
  // A request arriving while busy is dropped, so START
  // timing cannot be cut short
  assign idle      = (state_r == `ST_IDLE);               // RULE12
  assign go_start  = idle & wr_con2 & ~owned_r &
                     wb_dat_i[`CON2_START];
  assign go_rstart = idle & wr_con2 & owned_r &
                     wb_dat_i[`CON2_RSTART];              // RULE2
  assign go_stop   = idle & wr_con2 & owned_r &
                     ~wb_dat_i[`CON2_RSTART] &
                     wb_dat_i[`CON2_STOP];                // RULE17
  assign go_byte   = idle & wr_buf & owned_r;

  // ==========================================
  // Baud generator
  // Runs only while an operation is in flight: any accepted
  // request starts it, returning to idle stops it
  i2c_baud_gen u_baud (
    .clock  (clock),
    .rst_n  (rst_n),
    .run    (~idle),     // RULE9 RULE10
    .reload (reload_r),  // RULE7
    .tick   (tick)
  );

  // A released SCL held low by a slave stretches the phase
  assign advance = tick & (scl_low_r | scl_sync_r);

  // ==========================================
  // Completion detect
  // Byte ends after the ninth clock's falling edge
  assign done = advance & (
      ((state_r == `ST_START)  & (phase_r == 2'h1)) |
      ((state_r == `ST_RSTART) & (phase_r == 2'h3)) |
      ((state_r == `ST_STOP)   & (phase_r == 2'h2)) |
      ((state_r == `ST_BYTE)   & (phase_r == 2'h3) &
       (bit_r == `ACK_SLOT)));                      // RULE15

  // SDA level for the next slot: data MSB first in
  // transmit, released in receive, ack slot set apart
  assign drive_bit = byte_rx_r ? 1'b1 : shift_r[6];

  // ==========================================
  // Sequencer
  // Each step of an operation happens at the end of one baud phase; idle acts on a bus write at once
  always @(posedge clock) begin
    if (!rst_n) begin
      state_r     <= `ST_IDLE;
      phase_r     <= 2'h0;
      bit_r       <= 4'h0;
      shift_r     <= 8'h00;
      scl_low_r   <= 1'b0;
      sda_low_r   <= 1'b0;
      ack_stat_r  <= 1'b0;
      owned_r     <= 1'b0;
      addr_next_r <= 1'b0;
      rd_mode_r   <= 1'b0;
      byte_rx_r   <= 1'b0;
    end else begin
      case (state_r)
        `ST_IDLE: begin
          phase_r <= 2'h0;
          bit_r   <= 4'h0;
          if (go_start) begin
            state_r <= `ST_START;                   // RULE11
          end else if (go_rstart) begin
            state_r <= `ST_RSTART;
          end else if (go_stop) begin
            state_r <= `ST_STOP;
          end else if (go_byte) begin
            state_r <= `ST_BYTE;                    // RULE13 RULE16
            // After a read address, bytes are received
            byte_rx_r   <= ~addr_next_r & rd_mode_r;
            addr_next_r <= 1'b0;
            if (addr_next_r) begin
              rd_mode_r <= wb_dat_i[0];             // RULE3 RULE5
            end
            shift_r <= wb_dat_i[7:0];
            // First slot set up while SCL is still low
            if (~addr_next_r & rd_mode_r) begin
              sda_low_r <= 1'b0;
            end else begin
              sda_low_r <= ~wb_dat_i[7];            // RULE4
            end
          end
        end
        `ST_START: begin
          // SDA falls while SCL high, then SCL falls
          if (advance) begin
            phase_r <= phase_r + 2'h1;
            if (phase_r == 2'h0) begin
              sda_low_r <= 1'b1;                    // RULE1
            end else begin
              scl_low_r   <= 1'b1;
              owned_r     <= 1'b1;
              addr_next_r <= 1'b1;
              state_r     <= `ST_IDLE;              // RULE12
            end
          end
        end
        `ST_RSTART: begin
          // Release SDA, raise SCL, START, SCL low;
          // ownership stays, the bus is never freed
          if (advance) begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
              2'h0: begin
                sda_low_r <= 1'b0;
              end
              2'h1: begin
                scl_low_r <= 1'b0;
              end
              2'h2: begin
                sda_low_r <= 1'b1;                  // RULE2
              end
              default: begin
                scl_low_r   <= 1'b1;
                addr_next_r <= 1'b1;
                state_r     <= `ST_IDLE;
              end
            endcase
          end
        end
        `ST_STOP: begin
          // SDA low, SCL up, then SDA rises while SCL high
          if (advance) begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
              2'h0: begin
                sda_low_r <= 1'b1;
              end
              2'h1: begin
                scl_low_r <= 1'b0;
              end
              default: begin
                sda_low_r <= 1'b0;                  // RULE1
                owned_r   <= 1'b0;
                rd_mode_r <= 1'b0;
                state_r   <= `ST_IDLE;              // RULE18
              end
            endcase
          end
        end
        `ST_BYTE: begin
          if (advance) begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
              2'h0: begin
                // Rising SCL edge of this slot
                scl_low_r <= 1'b0;                  // RULE1
              end
              2'h1: begin
                // Sample mid-high: data or acknowledge
                if (bit_r == `ACK_SLOT) begin
                  if (!byte_rx_r) begin
                    ack_stat_r <= sda_sync_r;       // RULE4 RULE14
                  end
                end else if (byte_rx_r) begin
                  shift_r <= {shift_r[6:0], sda_sync_r};  // RULE6
                end
              end
              2'h2: begin
                scl_low_r <= 1'b1;
              end
              default: begin
                bit_r <= bit_r + 4'h1;
                if (bit_r == `ACK_SLOT) begin
                  // SCL stays low; SDA freed for the next step
                  sda_low_r <= 1'b0;
                  state_r   <= `ST_IDLE;            // RULE10
                end else if (bit_r == 4'h7) begin
                  // Ack slot: release, or send ack value
                  sda_low_r <= byte_rx_r & ~ack_dt_r;  // RULE6
                end else begin
                  sda_low_r <= ~drive_bit;          // RULE4
                  if (!byte_rx_r) begin
                    shift_r <= {shift_r[6:0], 1'b0};
                  end
                end
              end
            endcase
          end
        end
        default: begin
          state_r <= `ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Software registers
  // Setting the flag wins over a clear in the same cycle,
  // so no completion is ever lost
  always @(posedge clock) begin
    if (!rst_n) begin
      flag_r   <= 1'b0;
      ack_dt_r <= `ACKDT_RST;
      reload_r <= `BAUD_RST;
    end else begin
      if (done) begin
        flag_r <= 1'b1;                             // RULE12 RULE15 RULE18
      end else if (wr_stat & wb_dat_i[`STAT_FLAG]) begin
        flag_r <= 1'b0;                             // RULE20
      end
      if (wr_con2) begin
        ack_dt_r <= wb_dat_i[`CON2_ACKDT];
      end
      // Reload only changes between operations
      if (wr_baud & idle) begin
        reload_r <= wb_dat_i[6:0];                  // RULE8
      end
    end
  end

  // ==========================================
  // Read mux
  // Request bits read high while their condition runs
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `ADR_CON2: begin
        rd_nxt[`CON2_START]  = (state_r == `ST_START);
        rd_nxt[`CON2_RSTART] = (state_r == `ST_RSTART);
        rd_nxt[`CON2_STOP]   = (state_r == `ST_STOP);
        rd_nxt[`CON2_ACKDT]  = ack_dt_r;
        rd_nxt[`CON2_ACKST]  = ack_stat_r;          // RULE14
      end
      `ADR_BUF: begin
        rd_nxt[7:0] = shift_r;
      end
      `ADR_BAUD: begin
        rd_nxt[6:0] = reload_r;
      end
      `ADR_STAT: begin
        rd_nxt[`STAT_FLAG]   = flag_r;
        rd_nxt[`STAT_OWNED]  = owned_r;
        rd_nxt[`STAT_BUSY]   = ~idle;
        rd_nxt[`STAT_RDMODE] = rd_mode_r;
      end
      default: begin
        // Unmapped addresses read zero
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================
  // Wishbone answer
  // Every access is answered one cycle after it arrives;
  // ack drops the cycle after, giving a gap per access
  always @(posedge clock) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (req & ~wb_we_i) begin
        dat_r <= rd_nxt;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

endmodule // i2c_master_sequencer

// ==== tb/i2c_master_sequencer_checker.sv ====
// Concurrent checks on the sequencer's bus port and pins
`timescale 1ns/1ps
`include "i2c_master_defs.vh"

module i2c_master_sequencer_checker (
  input wire        clock,     // System clock
  input wire        rst_n,     // Reset, active low
  input wire        wb_cyc_i,  // Cycle
  input wire        wb_stb_i,  // Strobe
  input wire        wb_we_i,   // Write enable
  input wire [3:0]  wb_adr_i,  // Address
  input wire [31:0] wb_dat_i,  // Write data
  input wire [3:0]  wb_sel_i,  // Byte selects
  input wire [31:0] wb_dat_o,  // Read data
  input wire        wb_ack_o,  // Acknowledge
  input wire        scl_in,    // SCL level
  input wire        scl_out,   // SCL value
  input wire        scl_oe_n,  // SCL pull, active low
  input wire        sda_in,    // SDA level
  input wire        sda_out,   // SDA value
  input wire        sda_oe_n   // SDA pull, active low
);
  // ====================================
  // Shadow state; assumes the reload is written while idle
  reg         scl_q_r;  // Last SCL enable
  wire        wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];  // Taken write
  wire        rise    = scl_oe_n && !scl_q_r;                   // SCL released
  wire        req_wr  = wr_take && wb_adr_i == `ADR_CON2 && wb_dat_i[2:0] != 3'h0;  // Bus request
  reg  [6:0]  baud_r;   // Shadow reload
  reg  [15:0] gap_r;    // Cycles since last release
  reg  [3:0]  rise_r;   // Releases since buffer write
  reg         armed_r;  // A byte was started since the last bus request
  wire [15:0] per4    = ({9'h000, baud_r} + 16'h0001) << 4;      // One SCL period

  // Counters for period and pulse count
  always @(posedge clock) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      baud_r  <= `BAUD_RST;
      gap_r   <= 16'hFFFF;
      rise_r  <= 4'h0;
      armed_r <= 1'b0;
    end else begin
      scl_q_r <= scl_oe_n;
      gap_r   <= rise ? 16'h0001 : gap_r + {15'h0000, gap_r != 16'hFFFF};
      if (wr_take && wb_adr_i == `ADR_BAUD) begin
        baud_r <= wb_dat_i[6:0];
      end
      if (wr_take && wb_adr_i == `ADR_BUF) begin
        rise_r  <= 4'h0;
        armed_r <= 1'b1;
      end else if (rise && rise_r != 4'hF) begin
        rise_r <= rise_r + 4'h1;
      end
      if (req_wr) begin
        armed_r <= 1'b0;
      end
    end
  end

  // ====================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_lines_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin output value not zero");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge late or too long");
  chk_start_hold: assert property ($fell(sda_oe_n) && scl_oe_n |-> !sda_oe_n until !scl_oe_n)
    else $error("data released before clock pulled");
  chk_start_bound: assert property ($fell(sda_oe_n) && scl_oe_n |-> ##[1:1000] !scl_oe_n)
    else $error("start never completed");
  chk_stop_idle: assert property ($rose(sda_oe_n) && scl_oe_n |-> scl_oe_n until !sda_oe_n)
    else $error("clock pulled after stop");
  // Period taken inside a byte only; the low time after a Repeated START is shorter
  chk_scl_rate: assert property (rise && armed_r && rise_r != 4'h0 |-> gap_r >= per4)
    else $error("clock period too short");
  chk_nine_rises: assert property ((wr_take && wb_adr_i == `ADR_BUF || req_wr) && armed_r |-> rise_r == 4'h9)
    else $error("byte without nine clocks");
  chk_clock_stops: assert property (armed_r |-> rise_r <= 4'h9)
    else $error("clock ran on after byte");
  cov_start: cover property ($fell(sda_oe_n) && scl_oe_n);
  cov_stop: cover property ($rose(sda_oe_n) && scl_oe_n);
  cov_byte: cover property (armed_r && rise_r == 4'h9);
endmodule // i2c_master_sequencer_checker

bind i2c_master_sequencer i2c_master_sequencer_checker u_chk (.clock(clock), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));

// ==== tb/i2c_slave_model.sv ====
// Behavioural slave device on the two-wire bus
`timescale 1ns/1ps

module i2c_slave_model #(
  parameter [6:0] ADDR = 7'h2A  // Address that is answered
) (
  input  wire       scl,       // Resolved clock line
  input  wire       sda,       // Resolved data line
  input  wire [7:0] tx_byte,   // First byte returned on reads
  output reg        sda_pd_n,  // Data pull-down, active low
  output reg  [7:0] rx_byte,   // Last byte shifted in
  output reg        rx_ack     // Acknowledge seen from master
);
  reg       go;   // Repeated start seen
  reg       ev;   // Start or stop seen mid-byte
  reg       hit;  // Addressed and still talking
  reg       rd;   // Read transfer
  reg [7:0] cur;  // Byte being returned
  integer   i;    // Bit counter

  // ====================================
  // Eight bits in; a START or STOP ends it early
  task rx8;
    begin
      ev = 1'b0;
      for (i = 0; i < 8 && !ev; i = i + 1) begin
        @(posedge scl);
        rx_byte = {rx_byte[6:0], sda};
        @(negedge scl or sda);
        ev = scl;
      end
      go = ev & ~sda;
    end
  endtask

  // Ninth slot: only ever pulls low, never drives high
  task ack9(input pull);
    begin
      sda_pd_n = ~pull;
      @(negedge scl);
      sda_pd_n = 1'b1;
    end
  endtask

  // Eight bits out, MSB first, then the master's answer
  task tx8;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sda_pd_n = cur[i];
        @(negedge scl);
      end
      sda_pd_n = 1'b1;
      @(posedge scl);
      rx_ack = sda;
      @(negedge scl or sda);
      ev = scl;
      go = ev & ~sda;
      cur = ~cur;
    end
  endtask

  // ====================================
  // Frame loop: START, address, then bytes until STOP or NACK
  initial begin
    sda_pd_n = 1'b1;
    go = 1'b0;
    rx_byte = 8'h00;
    rx_ack = 1'b1;
    forever begin
      if (!go) begin
        @(negedge sda);
      end
      go = 1'b0;
      if (scl === 1'b1) begin
        rx8;
        rd = rx_byte[0];
        hit = !ev && rx_byte[7:1] == ADDR;
        cur = tx_byte;
        if (!ev) begin
          ack9(hit);
        end
        while (hit && !ev) begin
          if (rd) begin
            tx8;
            hit = !rx_ack;
          end else begin
            rx8;
            if (!ev) begin
              ack9(1'b1);
            end
          end
        end
      end
    end
  end
endmodule // i2c_slave_model

// ==== tb/tb.sv ====
// Self-checking bench for the two-wire master sequencer
`timescale 1ns/1ps
`include "i2c_master_defs.vh"

module tb;
  // ====================================
  // Signals
  localparam [6:0] SLV = 7'h2A;        // Slave address
  reg         clock, rst_n;            // Clock, reset active low
  reg         cyc, stb, we;            // Bus controls
  reg  [3:0]  adr, sel;                // Address, selects
  reg  [31:0] wdat, rd;                // Write data, last read
  reg  [7:0]  tx_byte;                 // Slave read data
  wire [31:0] wb_dat_o;                // Read data
  wire        wb_ack_o, scl_oe_n, sda_oe_n, sda_pd_n, rx_ack;
  wire [7:0]  rx_byte;                 // Byte seen by slave
  wire        scl = scl_oe_n;          // Pull-up, no stretching
  wire        sda = sda_oe_n & sda_pd_n;  // Wired-and with pull-up
  integer     fail_count, n_tests;     // Counters

  i2c_master_sequencer dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n));
  i2c_slave_model #(.ADDR(SLV)) slave (.scl(scl), .sda(sda), .tx_byte(tx_byte), .sda_pd_n(sda_pd_n),
    .rx_byte(rx_byte), .rx_ack(rx_ack));

  // Clock, 5 ns period
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ====================================
  // One classic cycle, held until ack is sampled
  task bus(input w, input [3:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      k = 0;
      @(posedge clock);
      while (wb_ack_o !== 1'b1 && k < 50) begin
        @(posedge clock);
        k = k + 1;
      end
      if (k >= 50) begin
        fail_count = fail_count + 1;
      end
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask

  // Compare one value
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // Read and compare under a mask
  task rchk(input [3:0] a, input [31:0] m, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0000_0000);
      chk(rd & m, exp);
    end
  endtask

  // Write, poll the completion flag, then clear it
  task op(input [3:0] a, input [31:0] d);
    integer k;
    begin
      bus(1'b1, a, d);
      k = 0;
      rd = 32'h0000_0000;
      while (rd[`STAT_FLAG] !== 1'b1 && k < 400) begin
        bus(1'b0, `ADR_STAT, 32'h0000_0000);
        k = k + 1;
      end
      chk(rd & 32'h0000_0001, 32'h0000_0001);
      bus(1'b1, `ADR_STAT, 32'h0000_0001);
    end
  endtask

  // Verdict and end of run
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask

  // Watchdog, well past the expected run
  initial begin
    #100000;
    fail_count = fail_count + 1;
    final_report;
  end

  // ====================================
  // Main sequence
  initial begin
    {cyc, stb, we, adr, wdat, sel, rst_n} = {3'h0, 4'h0, 32'h0000_0000, 4'h1, 1'b0};
    tx_byte = 8'h3C;
    fail_count = 0;
    n_tests = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rchk(`ADR_BAUD, 32'hFFFF_FFFF, {25'h0, `BAUD_RST});
    rchk(`ADR_STAT, 32'h0000_000F, 32'h0000_0000);
    rchk(4'h2, 32'hFFFF_FFFF, 32'h0000_0000);
    chk({30'h0, scl, sda}, 32'h0000_0003);
    bus(1'b1, `ADR_BAUD, 32'hFFFF_FF83);
    rchk(`ADR_BAUD, 32'hFFFF_FFFF, 32'h0000_0003);
    $display("test reset_baud done");
    op(`ADR_CON2, 32'h0000_0001);
    chk({30'h0, scl, sda}, 32'h0000_0000);
    bus(1'b1, `ADR_CON2, 32'h0000_0001);
    rchk(`ADR_STAT, 32'h0000_0006, 32'h0000_0002);
    op(`ADR_BUF, {24'h0, SLV, 1'b0});
    chk({24'h0, rx_byte}, {24'h0, SLV, 1'b0});
    rchk(`ADR_CON2, 32'h0000_0040, 32'h0000_0000);
    op(`ADR_BUF, 32'h0000_00A5);
    chk({24'h0, rx_byte}, 32'h0000_00A5);
    repeat (200) @(posedge clock);
    chk({31'h0, scl}, 32'h0000_0000);
    $display("test write done");
    op(`ADR_CON2, 32'h0000_0002);
    rchk(`ADR_STAT, 32'h0000_0002, 32'h0000_0002);
    op(`ADR_BUF, {24'h0, SLV ^ 7'h01, 1'b0});
    rchk(`ADR_CON2, 32'h0000_0040, 32'h0000_0040);
    $display("test nack done");
    op(`ADR_CON2, 32'h0000_0002);
    op(`ADR_BUF, {24'h0, SLV, 1'b1});
    chk({24'h0, rx_byte}, {24'h0, SLV, 1'b1});
    rchk(`ADR_STAT, 32'h0000_0008, 32'h0000_0008);
    op(`ADR_BUF, 32'h0000_0000);
    rchk(`ADR_BUF, 32'h0000_00FF, 32'h0000_003C);
    chk({31'h0, rx_ack}, 32'h0000_0000);
    bus(1'b1, `ADR_CON2, 32'h0000_0020);
    op(`ADR_BUF, 32'h0000_0000);
    rchk(`ADR_BUF, 32'h0000_00FF, 32'h0000_00C3);
    chk({31'h0, rx_ack}, 32'h0000_0001);
    $display("test read done");
    op(`ADR_CON2, 32'h0000_0024);
    rchk(`ADR_STAT, 32'h0000_0002, 32'h0000_0000);
    chk({30'h0, scl, sda}, 32'h0000_0003);
    $display("test stop done");
    final_report;
  end
endmodule // tb
